// >>> hw/frsfc_pkg.sv
// Package with shared constants and types for the fast role swap fault control block
// Function
// - Role-select change from 01b to 11b is taken as a fast role swap request.
// - Upper role-select going high during swap turns the sink path off.
// - After sink off, hold source off until VBUS is below vSafe5V.
// - If VBUS is already below vSafe5V, enable the source path at once.
// - Swap enables source with a boosted limit, then returns to 3-A.
// - Only the source path has fast turn-on; new-sink swaps are unsupported.
// - Fault output is active-low open drain, driven only for reporting faults.
// - Fault output stays low at least the hold time, then releases when clear.
// - Source undervoltage turns the source path off or keeps it off.
// - Undervoltage on a source request keeps disabled state without fault.
// - Undervoltage after source entry goes to source fault and asserts the fault.
// - Source overvoltage in or toward source state turns off and reports.
// - Current limit reports only when lasting longer than the fault delay.
// - Overtemperature in current limit turns off, reports, waits for fall threshold.
package frsfc_pkg;
  localparam int CLK_MHZ = 125;
  localparam int FAULT_HOLD_TIME_US = 1000;
  localparam int FAULT_HOLD_CYCLES = FAULT_HOLD_TIME_US * CLK_MHZ;
  localparam int ILIMIT_DELAY_US = 100;
  localparam int ILIMIT_DELAY_CYCLES = ILIMIT_DELAY_US * CLK_MHZ;
  localparam int CNT_W = 32;
  localparam logic [1:0] ROLE_DISABLED = 2'h0;
  localparam logic [1:0] ROLE_SINK = 2'h1;
  localparam logic [1:0] ROLE_SRC_1A5 = 2'h2;
  localparam logic [1:0] ROLE_SRC_3A = 2'h3;
  localparam int SYNC_LO = 0;
  localparam int SYNC_HI = 1;
  localparam int SYNC_SAFE5V = 2;
  localparam int SYNC_UV = 3;
  localparam int SYNC_OV = 4;
  localparam int SYNC_ILIM = 5;
  localparam int SYNC_OTR = 6;
  localparam int SYNC_OTF = 7;
  localparam int SYNC_W = 8;

  typedef enum {
    FRSFC_DISABLED,
    FRSFC_SINK,
    FRSFC_SWAP_WAIT,
    FRSFC_SOURCE,
    FRSFC_SRC_FAULT
  } frsfc_state_type;

  typedef enum logic [1:0] {
    FRSFC_LIM_1A5 = 2'h0,
    FRSFC_LIM_3A = 2'h1,
    FRSFC_LIM_BOOST = 2'h2
  } frsfc_limit_type;

  // Analog comparator flags
  typedef struct packed {
    logic below_safe5v;
    logic undervoltage;
    logic overvoltage;
    logic current_limit;
    logic overtemp_rise;
    logic overtemp_fall;
  } frsfc_flags_type;

  // Power path controls
  typedef struct packed {
    logic source_on;
    logic sink_on;
    frsfc_limit_type limit;
  } frsfc_path_type;
endpackage : frsfc_pkg

// >>> hw/frsfc_sync.sv
// Two-stage synchroniser bank for pin inputs
`timescale 1ns/1ps
`default_nettype none
module frsfc_sync
  import frsfc_pkg::*;
#(
  parameter int WIDTH = SYNC_W
)
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic clk_en_in,
  // Data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      meta_q <= '0;
      sync_out <= '0;
    end
    else if (clk_en_in)
    begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule : frsfc_sync
`default_nettype wire

// >>> hw/frsfc_timer.sv
// Retriggerable cycle counter with done flag
`timescale 1ns/1ps
`default_nettype none
module frsfc_timer
  import frsfc_pkg::*;
#(
  parameter logic [CNT_W-1:0] COUNT = CNT_W'(FAULT_HOLD_CYCLES)
)
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic clk_en_in,
  // Control
  input wire logic run_in,
  output logic done_out
);
  logic [CNT_W-1:0] cnt_q;

  // Counts while run is high, clears when low
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      cnt_q <= '0;
    end
    else if (clk_en_in)
    begin
      if (!run_in)
        cnt_q <= '0;
      else if (cnt_q < COUNT)
        cnt_q <= cnt_q + CNT_W'(1);
    end
  end

  assign done_out = run_in && (cnt_q >= COUNT);
endmodule : frsfc_timer
`default_nettype wire

// >>> hw/frsfc_top.sv
// Fast role swap sequencer and source-path fault reporting
`timescale 1ns/1ps
`default_nettype none
module frsfc_top
  import frsfc_pkg::*;
#(
  parameter int HOLD_CYCLES = FAULT_HOLD_CYCLES,
  parameter int ILIM_CYCLES = ILIMIT_DELAY_CYCLES
)
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic clk_en_in,
  // Role select pins
  input wire logic role_select_hi_in,
  input wire logic role_select_lo_in,
  // Comparator flags
  input wire frsfc_flags_type flags_in,
  // Power paths
  output frsfc_path_type path_out,
  // Fault pin, open drain
  output logic fault_n_out,
  output logic fault_n_oe_out,
  // Status
  output logic swap_active_out
);
  logic [SYNC_W-1:0] raw_s;
  logic [SYNC_W-1:0] sync_s;
  logic [1:0] role_s;
  logic [1:0] role_prev_q;
  logic below_safe5v_s;
  logic uv_s;
  logic ov_s;
  logic ilim_s;
  logic ot_rise_s;
  logic ot_fall_s;
  logic ilim_done_s;
  logic hold_done_s;
  logic swap_req_s;
  logic src_req_s;
  logic fault_evt_s;
  logic ot_latch_q;
  logic fault_q;
  logic [CNT_W-1:0] low_cnt_q;
  frsfc_state_type state_q;
  frsfc_state_type state_d;

  assign raw_s[SYNC_LO] = role_select_lo_in;
  assign raw_s[SYNC_HI] = role_select_hi_in;
  assign raw_s[SYNC_SAFE5V] = flags_in.below_safe5v;
  assign raw_s[SYNC_UV] = flags_in.undervoltage;
  assign raw_s[SYNC_OV] = flags_in.overvoltage;
  assign raw_s[SYNC_ILIM] = flags_in.current_limit;
  assign raw_s[SYNC_OTR] = flags_in.overtemp_rise;
  assign raw_s[SYNC_OTF] = flags_in.overtemp_fall;

  frsfc_sync #(
    .WIDTH(SYNC_W)
  ) u_sync (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .clk_en_in(clk_en_in),
    .async_in(raw_s),
    .sync_out(sync_s)
  );

  assign role_s = {sync_s[SYNC_HI], sync_s[SYNC_LO]};
  assign below_safe5v_s = sync_s[SYNC_SAFE5V];
  assign uv_s = sync_s[SYNC_UV];
  assign ov_s = sync_s[SYNC_OV];
  assign ilim_s = sync_s[SYNC_ILIM];
  assign ot_rise_s = sync_s[SYNC_OTR];
  assign ot_fall_s = sync_s[SYNC_OTF];

  // Current-limit persistence timer
  frsfc_timer #(
    .COUNT(CNT_W'(ILIM_CYCLES))
  ) u_ilim_timer (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .clk_en_in(clk_en_in),
    .run_in(ilim_s && (state_q == FRSFC_SOURCE)),
    .done_out(ilim_done_s)
  );

  // Fault hold timer
  frsfc_timer #(
    .COUNT(CNT_W'(HOLD_CYCLES))
  ) u_hold_timer (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .clk_en_in(clk_en_in),
    .run_in(fault_q),
    .done_out(hold_done_s)
  );

  // Previous role code
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      role_prev_q <= ROLE_DISABLED;
    else if (clk_en_in)
      role_prev_q <= role_s;
  end

  assign swap_req_s = (role_prev_q == ROLE_SINK) && (role_s == ROLE_SRC_3A);
  assign src_req_s = role_s[1];

  // Overtemperature latch, cleared at fall threshold
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      ot_latch_q <= 1'b0;
    else if (clk_en_in)
    begin
      if (ot_rise_s && ilim_s && src_req_s)
        ot_latch_q <= 1'b1;
      else if (ot_fall_s)
        ot_latch_q <= 1'b0;
    end
  end

  // Reporting faults on the source side
  always_comb
  begin
    fault_evt_s = 1'b0;
    if (src_req_s && ov_s)
      fault_evt_s = 1'b1;
    if (ilim_done_s)
      fault_evt_s = 1'b1;
    if (src_req_s && ot_rise_s && ilim_s)
      fault_evt_s = 1'b1;
    if (state_q == FRSFC_SOURCE && uv_s)
      fault_evt_s = 1'b1;
  end

  // Sequencer next state
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      FRSFC_DISABLED:
      begin
        if (role_s == ROLE_SINK)
          state_d = FRSFC_SINK;
        else if (src_req_s && !uv_s && !ov_s && !ot_latch_q)
          state_d = FRSFC_SOURCE;
      end
      FRSFC_SINK:
      begin
        if (swap_req_s)
          state_d = FRSFC_SWAP_WAIT;
        else if (role_s != ROLE_SINK)
          state_d = FRSFC_DISABLED;
      end
      FRSFC_SWAP_WAIT:
      begin
        if (role_s != ROLE_SRC_3A)
          state_d = FRSFC_DISABLED;
        else if (uv_s || ov_s || ot_latch_q)
          state_d = FRSFC_SRC_FAULT;
        else if (below_safe5v_s)
          state_d = FRSFC_SOURCE;
      end
      FRSFC_SOURCE:
      begin
        if (!src_req_s)
          state_d = FRSFC_DISABLED;
        else if (uv_s || ov_s || ot_latch_q || fault_evt_s)
          state_d = FRSFC_SRC_FAULT;
      end
      FRSFC_SRC_FAULT:
      begin
        if (!src_req_s)
          state_d = FRSFC_DISABLED;
        else if (!uv_s && !ov_s && !ot_latch_q)
          state_d = FRSFC_DISABLED;
      end
      default:
        state_d = FRSFC_DISABLED;
    endcase
  end

  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      state_q <= FRSFC_DISABLED;
    else if (clk_en_in)
      state_q <= state_d;
  end

  // Swap flag, cleared once source is reached
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      swap_active_out <= 1'b0;
    else if (clk_en_in)
    begin
      if (state_d == FRSFC_SWAP_WAIT)
        swap_active_out <= 1'b1;
      else if (state_q == FRSFC_SOURCE || state_d != FRSFC_SOURCE)
        swap_active_out <= 1'b0;
    end
  end

  // Path controls, registered
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      path_out <= '{source_on: 1'b0, sink_on: 1'b0, limit: FRSFC_LIM_1A5};
    end
    else if (clk_en_in)
    begin
      path_out.sink_on <= (state_d == FRSFC_SINK);
      path_out.source_on <= (state_d == FRSFC_SOURCE) && !uv_s;
      if (state_d == FRSFC_SOURCE && state_q == FRSFC_SWAP_WAIT)
        path_out.limit <= FRSFC_LIM_BOOST;
      else if (role_s == ROLE_SRC_3A)
        path_out.limit <= FRSFC_LIM_3A;
      else
        path_out.limit <= FRSFC_LIM_1A5;
    end
  end

  // Fault latch with minimum hold
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      fault_q <= 1'b0;
    else if (clk_en_in)
    begin
      if (fault_evt_s)
        fault_q <= 1'b1;
      else if (hold_done_s && !uv_s && !ov_s && !ot_latch_q && !ilim_s)
        fault_q <= 1'b0;
    end
  end

  // Open-drain pin
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      fault_n_out <= 1'b1;
      fault_n_oe_out <= 1'b0;
    end
    else if (clk_en_in)
    begin
      fault_n_out <= !(fault_evt_s || (fault_q && !(hold_done_s && !uv_s && !ov_s && !ot_latch_q && !ilim_s)));
      fault_n_oe_out <= fault_evt_s || (fault_q && !(hold_done_s && !uv_s && !ov_s && !ot_latch_q && !ilim_s));
    end
  end

  // Cycles the fault pin has been driven
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      low_cnt_q <= '0;
    else if (clk_en_in)
    begin
      if (!fault_n_oe_out)
        low_cnt_q <= '0;
      else if (low_cnt_q < CNT_W'(HOLD_CYCLES))
        low_cnt_q <= low_cnt_q + CNT_W'(1);
    end
  end

  AST_SINK_OFF_ON_SWAP: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    clk_en_in && state_q == FRSFC_SWAP_WAIT |=> !path_out.sink_on || !clk_en_in)
    else $error("Sink path on during swap");
  AST_SOURCE_WAITS: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    clk_en_in && state_q == FRSFC_SWAP_WAIT && !below_safe5v_s |=> !path_out.source_on)
    else $error("Source on before vSafe5V");
  AST_SWAP_FROM_SINK: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    clk_en_in && state_q == FRSFC_SINK && $past(role_s) == ROLE_SINK && role_s == ROLE_SRC_3A
    |=> state_q == FRSFC_SWAP_WAIT || !$past(clk_en_in))
    else $error("Swap request missed");
  AST_FAST_ENABLE: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    clk_en_in && state_q == FRSFC_SWAP_WAIT && role_s == ROLE_SRC_3A && below_safe5v_s && !uv_s && !ov_s
    && !ot_latch_q |=> path_out.source_on && path_out.limit == FRSFC_LIM_BOOST)
    else $error("Source not enabled at once");
  AST_OD_PIN: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    fault_n_oe_out == !fault_n_out)
    else $error("Fault pin drives high");
  AST_HOLD: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    $rose(fault_q) |-> fault_q [*8])
    else $error("Fault released early");
  AST_UV_OFF: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    clk_en_in && uv_s |=> !path_out.source_on)
    else $error("Source on in undervoltage");
  AST_UV_NO_FAULT: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    clk_en_in && state_q == FRSFC_DISABLED && uv_s && !ov_s && !ilim_s && !fault_q |=> fault_n_out)
    else $error("Fault on source request in undervoltage");
  AST_OV_FAULT: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    clk_en_in && src_req_s && ov_s |=> !fault_n_out && !path_out.source_on)
    else $error("Overvoltage not reported");
  AST_ILIM_SHORT: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    clk_en_in && state_q == FRSFC_SOURCE && $rose(ilim_s) && !ov_s && !ot_rise_s && !uv_s && !fault_q
    |=> fault_n_out)
    else $error("Short current limit reported");
  AST_HOLD_MIN: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    clk_en_in && fault_n_oe_out && low_cnt_q < CNT_W'(HOLD_CYCLES) |=> fault_n_oe_out)
    else $error("Fault pin released before hold time");
  AST_BOOST_ONE: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    clk_en_in && path_out.limit == FRSFC_LIM_BOOST |=> path_out.limit != FRSFC_LIM_BOOST)
    else $error("Boost limit kept after swap");
  AST_OT_OFF: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    clk_en_in && ot_latch_q |=> !path_out.source_on)
    else $error("Source on while overheated");

  COV_SWAP: cover property (@(posedge clk_in) state_q == FRSFC_SWAP_WAIT ##1 state_q == FRSFC_SOURCE);
  COV_FAULT: cover property (@(posedge clk_in) $fell(fault_n_out));
  COV_RELEASE: cover property (@(posedge clk_in) $rose(fault_n_out));
  COV_OT: cover property (@(posedge clk_in) $rose(ot_latch_q));
endmodule : frsfc_top
`default_nettype wire

// >>> verification/frsfc_pd_model.sv
// Port controller model driving the role-select pins
`timescale 1ns/1ps
`default_nettype none
module frsfc_pd_model
  import frsfc_pkg::*;
(
  // Clock
  input wire logic clk_in,
  // Wanted role
  input wire logic [1:0] role_code_in,
  input wire logic fast_swap_in,
  // Pins
  output logic role_select_hi_out,
  output logic role_select_lo_out
);
  logic [1:0] pins_q = ROLE_DISABLED;
  logic [2:0] gap_q = 3'h0;
  assign {role_select_hi_out, role_select_lo_out} = pins_q;
  always @(negedge clk_in)
  begin
    if (gap_q != 3'h0)
      gap_q <= gap_q - 3'h1;
    else if (pins_q != role_code_in)
    begin
      if (fast_swap_in && pins_q == ROLE_SINK && role_code_in == ROLE_SRC_3A)
        pins_q <= role_code_in;
      else if (pins_q != ROLE_DISABLED && role_code_in != ROLE_DISABLED &&
               (pins_q == ROLE_SINK || role_code_in == ROLE_SINK))
      begin
        pins_q <= ROLE_DISABLED;
        gap_q <= 3'h4;
      end
      else
        pins_q <= role_code_in;
    end
  end
endmodule : frsfc_pd_model
`default_nettype wire

// >>> verification/frsfc_top_tb.sv
// Self-checking bench for the swap and fault block
`timescale 1ns/1ps
`default_nettype none
module frsfc_top_tb
  import frsfc_pkg::*;
;
  localparam int HOLD = 20;
  localparam int ILIM = 10;
  logic clk_in;
  logic sys_rst_in;
  logic [1:0] code;
  logic fsw;
  logic hi;
  logic lo;
  frsfc_flags_type flg;
  frsfc_path_type path;
  logic flt_n;
  logic flt_oe;
  logic swap;
  logic en;
  int errors;
  int cmp_count;
  int len;

  frsfc_pd_model frsfc_pd_model_i (.clk_in(clk_in), .role_code_in(code), .fast_swap_in(fsw),
    .role_select_hi_out(hi), .role_select_lo_out(lo));
  frsfc_top #(.HOLD_CYCLES(HOLD), .ILIM_CYCLES(ILIM)) frsfc_top_i (.clk_in(clk_in),
    .sys_rst_in(sys_rst_in), .clk_en_in(en), .role_select_hi_in(hi), .role_select_lo_in(lo),
    .flags_in(flg), .path_out(path), .fault_n_out(flt_n), .fault_n_oe_out(flt_oe),
    .swap_active_out(swap));

  task automatic results();
    $display("compares %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : results

  task automatic check(input string nm, input logic [3:0] seen, input logic [3:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  // 0 source, 1 sink, 2 fault drive, 3 swap, 4 limit
  function automatic logic [3:0] cur(input int sel);
    case (sel)
      0: return {3'h0, path.source_on};
      1: return {3'h0, path.sink_on};
      2: return {3'h0, flt_oe};
      3: return {3'h0, swap};
      default: return {2'h0, path.limit};
    endcase
  endfunction : cur

  task automatic wt(input int sel, input logic [3:0] v, input int n, input string nm);
    int k;
    k = 0;
    while (cur(sel) !== v && k < n)
    begin
      @(negedge clk_in);
      k++;
    end
    check(nm, cur(sel), v);
    if (cur(sel) !== v)
      results();
  endtask : wt

  task automatic hold(input int sel, input logic [3:0] v, input int n, input string nm);
    logic [3:0] seen;
    seen = v;
    repeat (n)
    begin
      @(negedge clk_in);
      if (cur(sel) !== v)
        seen = cur(sel);
    end
    check(nm, seen, v);
  endtask : hold

  task automatic role(input logic [1:0] c, input logic f);
    @(negedge clk_in);
    code <= c;
    fsw <= f;
  endtask : role

  initial
  begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end

  always @(negedge clk_in)
    if (!sys_rst_in && path.source_on && path.sink_on)
      check("paths", 4'h1, 4'h0);

  initial
  begin
    sys_rst_in = 1'b1;
    code = ROLE_DISABLED;
    fsw = 1'b0;
    en = 1'b1;
    flg = '0;
    errors = 0;
    cmp_count = 0;
    void'($urandom(79206));
    repeat (6) @(posedge clk_in);
    @(negedge clk_in);
    sys_rst_in <= 1'b0;
    check("reset path", path, 4'h0);
    check("reset drive", cur(2), 4'h0);
    check("reset data", {3'h0, flt_n}, 4'h1);
    $display("test reset done");
    for (int c = 0; c < 2; c++)
    begin
      role(ROLE_DISABLED, 1'b0);
      wt(0, 4'h0, 20, "source off");
      flg.below_safe5v <= c[0];
      role(ROLE_SINK, 1'b0);
      wt(1, 4'h1, 20, "sink on");
      role(ROLE_SRC_3A, 1'b1);
      wt(1, 4'h0, 8, "sink off");
      check("swap active", cur(3), 4'h1);
      if (c == 0)
      begin
        hold(0, 4'h0, HOLD, "source held");
        flg.below_safe5v <= 1'b1;
      end
      wt(0, 4'h1, 6, "source on");
      check("boost", cur(4), {2'h0, FRSFC_LIM_BOOST});
      @(negedge clk_in);
      check("limit 3A", cur(4), {2'h0, FRSFC_LIM_3A});
      check("swap done", cur(3), 4'h0);
      $display("test swap %0d done", c);
    end
    role(ROLE_SRC_1A5, 1'b0);
    wt(4, {2'h0, FRSFC_LIM_1A5}, 10, "limit 1.5A");
    check("source kept", cur(0), 4'h1);
    role(ROLE_DISABLED, 1'b0);
    wt(0, 4'h0, 10, "source off");
    flg.undervoltage <= 1'b1;
    role(ROLE_SRC_3A, 1'b0);
    hold(2, 4'h0, HOLD, "no fault");
    check("refused", cur(0), 4'h0);
    flg.undervoltage <= 1'b0;
    wt(0, 4'h1, 10, "source up");
    $display("test refusal done");
    for (int k = 0; k < 3; k++)
    begin
      @(negedge clk_in);
      en <= (k != 1);
      flg.undervoltage <= (k == 0);
      flg.overvoltage <= (k == 1);
      flg.current_limit <= (k == 2);
      flg.overtemp_rise <= (k == 2);
      if (k == 1)
      begin
        hold(2, 4'h0, 8, "frozen pin");
        check("frozen path", cur(0), 4'h1);
        en <= 1'b1;
      end
      wt(2, 4'h1, 8, "fault on");
      check("pin low", {3'h0, flt_n}, 4'h0);
      check("source cut", cur(0), 4'h0);
      flg <= '0;
      hold(2, 4'h1, HOLD - 2, "fault held");
      if (k == 2)
      begin
        hold(0, 4'h0, 10, "still hot");
        flg.overtemp_fall <= 1'b1;
      end
      wt(2, 4'h0, 12, "fault off");
      wt(0, 4'h1, 12, "source back");
      flg.overtemp_fall <= 1'b0;
      $display("test fault %0d done", k);
    end
    repeat (4)
    begin
      len = 1 + $urandom % 6;
      @(negedge clk_in);
      flg.current_limit <= 1'b1;
      repeat (len) @(negedge clk_in);
      flg.current_limit <= 1'b0;
      hold(2, 4'h0, 2 * ILIM, "short limit");
    end
    flg.current_limit <= 1'b1;
    hold(2, 4'h0, ILIM - 2, "limit early");
    wt(2, 4'h1, 10, "limit fault");
    $display("test current limit done");
    @(negedge clk_in);
    sys_rst_in <= 1'b1;
    flg <= '0;
    @(negedge clk_in);
    check("mid reset path", path, 4'h0);
    check("mid reset drive", cur(2), 4'h0);
    check("mid reset swap", cur(3), 4'h0);
    sys_rst_in <= 1'b0;
    wt(0, 4'h1, 10, "source after reset");
    check("limit after reset", cur(4), {2'h0, FRSFC_LIM_3A});
    check("drive after reset", cur(2), 4'h0);
    $display("test mid reset done");
    results();
  end
endmodule : frsfc_top_tb
`default_nettype wire
